// ### design/rt_circ_pkg.sv
package rt_circ_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] CFG1_OFS = 8'h00;
  localparam logic [7:0] CFG2_OFS = 8'h04;
  localparam logic [7:0] IER_OFS = 8'h08;
  localparam logic [7:0] PEND_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] LOGIDX_OFS = 8'h14;

  // Configuration field positions.
  localparam int UNDEF_MODE_INVALID_BIT = 0;
  localparam int SPLIT_BIT = 1;
  localparam int BWMS_BIT = 3;

  // Pending and enable bit positions.
  localparam int BDONE_BIT = 0;
  localparam int IWA_BIT = 1;

  // Reset values of the software registers.
  localparam logic [1:0] CFG1_RST = 2'h0;
  localparam logic IRQ_CFG_RST = 1'b0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Descriptor control word fields.
  localparam int BSIZE_LSB = 4;
  localparam int BLOCK_DONE_IRQ_ENABLE_BIT = 2;
  localparam int IWA_CTL_BIT = 15;
  localparam int IWA_BC_CTL_BIT = 14;

  // Descriptor word offsets and RAM areas.
  localparam logic [15:0] DESC_CA_OFS = 16'h0002;
  localparam logic [15:0] DESC_MSG_INFO_POINTER_OFS = 16'h0003;
  localparam logic [15:0] LOG_BASE = 16'h0180;
  localparam logic [15:0] MODE_DESC_BASE = 16'h0100;

  // Word layouts.
  localparam int ST_ME_BIT = 10;
  localparam int ST_DBCA_BIT = 1;
  localparam int MI_MARK_BIT = 13;
  localparam logic [15:0] IIW_IWA = 16'h0002;
  localparam logic [5:0] FULL_WC = 6'h20;
  localparam logic [4:0] MODE_DATA_MIN = 5'h10;

  // Response given to a command.
  typedef enum logic [1:0] {RESP_NONE, RESP_STATUS, RESP_STATUS_DATA}
    resp_t;

  // Command as decoded by the protocol engine, with its descriptor.
  typedef struct packed {
    logic txNotRx;
    logic broadcast;
    logic rt31;
    logic modeCmd;
    logic [4:0] code;
    logic [4:0] wordCount;
    logic busy;
    logic illegal;
    logic [15:0] ctrl;
    logic [15:0] startPtr;
    logic [15:0] currPtr;
    logic [15:0] mibaPtr;
    logic [15:0] descAddr;
    logic [15:0] timeTag;
  } msg_evt_t;

  // One RAM write.
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } ram_wr_t;

endpackage

// ### design/rt_circular_buffer_and_mode_cmd.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Receive data goes to current pointer onward.
// R2 - Store info and tag before pointer update.
// R3 - Advance both pointers while block unfinished.
// R4 - Reload pointers at block end by code.
// R5 - Block-done interrupt needs both enables.
// R6 - Transmit fetch starts at current pointer.
// R7 - Transmit stores info then updates pointers.
// R8 - Broadcast data shares the same buffer.
// R9 - Marker select puts broadcast in bit 13.
// R10 - Broadcast transmit: no reply, pointers held.
// R11 - Invalid option covers 22 undefined codes.
// R12 - Invalid option cleared on reset.
// R13 - Illegal sets error, status only.
// R14 - Invalid undefined codes: no response, status kept.
// R15 - Reset table zero gives in-form replies.
// R16 - Bus control acceptance bit never set.
// R17 - Mode interrupts from top control bits.
// R18 - Broadcast interrupts only for codes 0-15.
// R19 - Accessed interrupt sets pending and line.
// R20 - Log info and address before line.
// R21 - Bad message keeps info pointer.
// R22 - Increment once, test full, else add two.
// R23 - Host programs power-of-two block code.
module rt_circular_buffer_and_mode_cmd (
  // Clock and synchronous reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Message events from the protocol engine.
  input wire logic msgStart,
  input wire rt_circ_pkg::msg_evt_t msgEvt,
  input wire logic rxValid,
  input wire logic [15:0] rxWord,
  input wire logic txReq,
  input wire logic msgEnd,
  input wire logic msgError,
  input wire logic gapError,
  // Response and status toward the encoder.
  output logic respValid,
  output rt_circ_pkg::resp_t respKind,
  output logic [15:0] statusWord,
  // Shared RAM access.
  output rt_circ_pkg::ram_wr_t ramWr,
  output logic fetchValid,
  output logic [15:0] fetchAddr,
  // Message interrupt output.
  output logic msgIntLine
);

  // Sequencer states.
  typedef enum logic [3:0] {IDLE, DATA, INFO, TTAG, DCA, DMIBA, LOGI, LOGA}
    state_t;

  state_t state_ff, nxt_state;
  rt_circ_pkg::msg_evt_t evt_ff; // Command latched at message start.
  logic [1:0] cfg1_ff; // Undefined-invalid and split-data options.
  logic bwms_ff; // Broadcast marker select.
  logic [1:0] ier_ff; // Interrupt enables.
  logic [1:0] pend_ff, nxt_pend; // Sticky pending interrupts.
  logic [3:0] logIdx_ff; // Next interrupt log slot.
  logic logDone_ff; // Log address word is on the RAM write port in this cycle.
  logic [5:0] idx_ff; // Data word index inside the message.
  logic err_ff, gap_ff; // End-of-message flags.
  logic meFlag_ff; // Transfer error bit of the status word.
  logic [15:0] lastCmd_ff; // Last accepted command, kept for status.

  // AHB data-phase state; every transfer takes one wait state.
  logic busy_ff, wr_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;

  // Output flops.
  logic respValid_ff;
  rt_circ_pkg::resp_t respKind_ff;
  rt_circ_pkg::ram_wr_t ramWr_ff;
  logic fetchValid_ff;
  logic [15:0] fetchAddr_ff;
  logic msgIntLine_ff;

  // Command decode of the incoming event.
  wire logic [4:0] inCode = msgEvt.code;
  wire logic inTx = msgEvt.txNotRx;
  // The 22 undefined mode commands. R11
  wire logic undefCode = msgEvt.modeCmd & ((!inTx & !inCode[4]) |
    (!inTx & (inCode == 5'h10 || inCode == 5'h12 || inCode == 5'h13)) |
    (inTx & (inCode == 5'h11 || inCode == 5'h14 || inCode == 5'h15)));
  // Ignored only while the option is set. R14
  wire logic ignoreCmd = undefCode & cfg1_ff[rt_circ_pkg::UNDEF_MODE_INVALID_BIT];
  wire logic bcTx = msgEvt.broadcast & inTx;
  wire logic noXmit = bcTx & msgEvt.rt31; // R10
  // Mode-data replies only for legal codes 16-31 with T/R set. R15
  wire logic withData = inTx & !msgEvt.illegal &
    (!msgEvt.modeCmd | inCode >= rt_circ_pkg::MODE_DATA_MIN);
  wire rt_circ_pkg::resp_t inResp = (msgEvt.broadcast || noXmit) ?
    rt_circ_pkg::RESP_NONE : withData ? rt_circ_pkg::RESP_STATUS_DATA :
    rt_circ_pkg::RESP_STATUS; // R13
  // Top control bits choose the mode interrupts. R17
  wire logic iwaCtl = msgEvt.broadcast ?
    (msgEvt.ctrl[rt_circ_pkg::IWA_BC_CTL_BIT] & !inCode[4]) : // R18
    msgEvt.ctrl[rt_circ_pkg::IWA_CTL_BIT];
  wire logic iwaFire = iwaCtl & ier_ff[rt_circ_pkg::IWA_BIT]; // R19

  // Pointer arithmetic for the latched message.
  wire logic [3:0] bsize = evt_ff.ctrl[rt_circ_pkg::BSIZE_LSB +: 4];
  wire logic [15:0] lowMask = ~(16'hffff << bsize); // R4
  wire logic [15:0] mibaInc = evt_ff.mibaPtr + 16'h0001; // R22
  wire logic fullCount = (mibaInc & lowMask) == lowMask; // R22
  wire logic [5:0] wcN = (evt_ff.wordCount == 5'h00) ?
    rt_circ_pkg::FULL_WC : {1'b0, evt_ff.wordCount};
  wire logic [15:0] newCa = fullCount ? evt_ff.startPtr :
    evt_ff.currPtr + {10'h000, wcN}; // R3 R4
  wire logic [15:0] newMiba = fullCount ? (evt_ff.mibaPtr & ~lowMask) :
    evt_ff.mibaPtr + 16'h0002; // R3 R4 R22
  // Pointers move only for clean messages that are not broadcast transmits. R21 R10
  wire logic goodMsg = !err_ff & !evt_ff.busy & !evt_ff.illegal &
    !(evt_ff.broadcast & evt_ff.txNotRx);
  wire logic dataAddrOk = idx_ff < wcN;
  wire logic [15:0] dataAddr = evt_ff.currPtr + {10'h000, idx_ff};

  // Message information word; bit 13 is gap or broadcast marker. R9
  wire logic markBit = bwms_ff ? evt_ff.broadcast : gap_ff;
  wire logic [15:0] infoWord = {err_ff, evt_ff.busy, markBit,
    evt_ff.illegal, evt_ff.txNotRx, evt_ff.code, 1'b0, evt_ff.wordCount};
  wire logic [15:0] logAddr = rt_circ_pkg::LOG_BASE +
    {11'h000, logIdx_ff, 1'b0};
  wire logic [15:0] modeDesc = rt_circ_pkg::MODE_DESC_BASE +
    {8'h00, evt_ff.txNotRx, evt_ff.code, 2'b00}; // R20

  // Block done raises the buffer interrupt only with both enables. R5
  wire logic bdoneSet = (state_ff == DMIBA) & fullCount &
    evt_ff.ctrl[rt_circ_pkg::BLOCK_DONE_IRQ_ENABLE_BIT] & ier_ff[rt_circ_pkg::BDONE_BIT];
  // Pending is set only once both log words have landed in RAM.
  wire logic iwaSet = logDone_ff; // R19 R20

  // AHB decode.
  wire logic ahbTake = hsel & htrans[1] & hready;
  wire logic busWr = busy_ff & wr_ff;
  wire logic [31:0] pendClr = (busWr && addr_ff == rt_circ_pkg::PEND_OFS) ?
    hwdata : 32'h0;
  wire logic [31:0] rdMux =
    (addr_ff == rt_circ_pkg::CFG1_OFS) ? {30'h0, cfg1_ff} :
    (addr_ff == rt_circ_pkg::CFG2_OFS) ?
      {28'h0, bwms_ff, 3'h0} :
    (addr_ff == rt_circ_pkg::IER_OFS) ? {30'h0, ier_ff} :
    (addr_ff == rt_circ_pkg::PEND_OFS) ? {30'h0, pend_ff} :
    (addr_ff == rt_circ_pkg::STAT_OFS) ? {lastCmd_ff, statusWord} :
    (addr_ff == rt_circ_pkg::LOGIDX_OFS) ? {28'h0, logIdx_ff} : 32'h0;

  // Sticky pending bits: a set in the clearing cycle wins.
  always_comb begin
    nxt_pend = (pend_ff & ~pendClr[1:0]) | {iwaSet, bdoneSet};
  end

  // Next state of the message sequencer.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IDLE: begin
        if (msgStart && !ignoreCmd) begin
          nxt_state = msgEvt.modeCmd ? (iwaFire ? LOGI : IDLE) : DATA;
        end
      end
      DATA: begin
        if (msgEnd) begin
          nxt_state = INFO;
        end
      end
      INFO: nxt_state = TTAG;
      TTAG: nxt_state = goodMsg ? DCA : IDLE; // R2 R21
      DCA: nxt_state = DMIBA;
      DMIBA: nxt_state = IDLE;
      LOGI: nxt_state = LOGA;
      LOGA: nxt_state = IDLE;
    endcase
  end

  // Sequencer, latches and counters.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= IDLE;
      evt_ff <= '0;
      idx_ff <= 6'h00;
      err_ff <= 1'b0;
      gap_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == IDLE && msgStart) begin
        evt_ff <= msgEvt;
        idx_ff <= 6'h00;
        err_ff <= 1'b0;
        gap_ff <= 1'b0;
      end else if (state_ff == DATA) begin
        // Broadcast and plain receive data share one buffer. R8
        if ((rxValid && !evt_ff.txNotRx) || (txReq && evt_ff.txNotRx)) begin
          idx_ff <= idx_ff + 6'h01;
        end
        if (msgEnd) begin
          err_ff <= msgError;
          gap_ff <= gapError;
        end
      end
    end
  end

  // Status word, response pulse and last command.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meFlag_ff <= 1'b0;
      lastCmd_ff <= 16'h0000;
      respValid_ff <= 1'b0;
      respKind_ff <= rt_circ_pkg::RESP_NONE;
    end else begin
      respValid_ff <= 1'b0;
      // Ignored commands leave status untouched. R14
      if (state_ff == IDLE && msgStart && !ignoreCmd) begin
        meFlag_ff <= msgEvt.illegal; // R13
        lastCmd_ff <= {4'h0, msgEvt.txNotRx, msgEvt.modeCmd, msgEvt.code,
          msgEvt.wordCount};
        respValid_ff <= 1'b1;
        respKind_ff <= inResp; // R13 R10 R15
      end
    end
  end

  // Bus control acceptance stays zero; no bus controller exists here.
  always_comb begin
    statusWord = 16'h0000;
    statusWord[rt_circ_pkg::ST_ME_BIT] = meFlag_ff;
    statusWord[rt_circ_pkg::ST_DBCA_BIT] = 1'b0; // R16
  end

  // RAM write stream: data, info, tag, pointers and log.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ramWr_ff <= '0;
    end else begin
      ramWr_ff <= '0;
      unique case (state_ff)
        DATA: begin
          if (rxValid && !evt_ff.txNotRx && dataAddrOk) begin
            ramWr_ff <= '{1'b1, dataAddr, rxWord}; // R1
          end
        end
        INFO: ramWr_ff <= '{1'b1, evt_ff.mibaPtr, infoWord}; // R2 R7
        TTAG: ramWr_ff <= '{1'b1, evt_ff.mibaPtr + 16'h0001,
          evt_ff.timeTag}; // R2 R7
        DCA: ramWr_ff <= '{1'b1, evt_ff.descAddr + rt_circ_pkg::DESC_CA_OFS,
          newCa}; // R3 R4
        DMIBA: ramWr_ff <= '{1'b1,
          evt_ff.descAddr + rt_circ_pkg::DESC_MSG_INFO_POINTER_OFS, newMiba}; // R3 R4
        LOGI: ramWr_ff <= '{1'b1, logAddr,
          rt_circ_pkg::IIW_IWA}; // R20
        LOGA: ramWr_ff <= '{1'b1, logAddr + 16'h0001, modeDesc}; // R20
        default: ramWr_ff <= '0;
      endcase
    end
  end

  // Transmit data fetch; no fetch when the reply is suppressed.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fetchValid_ff <= 1'b0;
      fetchAddr_ff <= 16'h0000;
    end else begin
      fetchValid_ff <= (state_ff == DATA) & txReq & evt_ff.txNotRx &
        !evt_ff.broadcast & !evt_ff.illegal & dataAddrOk;
      fetchAddr_ff <= dataAddr; // R6
    end
  end

  // Log slot, pending bits and the interrupt line. The line follows
  // the log writes by one cycle so software finds the entry in place.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pend_ff <= rt_circ_pkg::IRQ_RST;
      logIdx_ff <= 4'h0;
      logDone_ff <= 1'b0;
      msgIntLine_ff <= 1'b0;
    end else begin
      logDone_ff <= (state_ff == LOGA); // R20
      pend_ff <= nxt_pend;
      msgIntLine_ff <= |(nxt_pend & ier_ff); // R5 R19
      if (iwaSet) begin
        logIdx_ff <= logIdx_ff + 4'h1;
      end
    end
  end

  // Configuration registers; the invalid option clears on reset. R12
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg1_ff <= rt_circ_pkg::CFG1_RST;
      bwms_ff <= rt_circ_pkg::IRQ_CFG_RST;
      ier_ff <= rt_circ_pkg::IRQ_RST;
    end else if (busWr) begin
      if (addr_ff == rt_circ_pkg::CFG1_OFS) begin
        cfg1_ff <= hwdata[1:0];
      end
      if (addr_ff == rt_circ_pkg::CFG2_OFS) begin
        bwms_ff <= hwdata[rt_circ_pkg::BWMS_BIT];
      end
      if (addr_ff == rt_circ_pkg::IER_OFS) begin
        ier_ff <= hwdata[1:0];
      end
    end
  end

  // AHB-Lite slave: address phase, then one wait state, then answer.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
      hreadyout_ff <= 1'b1;
    end else if (busy_ff) begin
      busy_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= wr_ff ? 32'h0 : rdMux;
    end else if (ahbTake) begin
      busy_ff <= 1'b1;
      wr_ff <= hwrite;
      addr_ff <= {haddr[7:2], 2'b00};
      hreadyout_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign respValid = respValid_ff;
  assign respKind = respKind_ff;
  assign ramWr = ramWr_ff;
  assign fetchValid = fetchValid_ff;
  assign fetchAddr = fetchAddr_ff;
  assign msgIntLine = msgIntLine_ff;

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence logWrites;
    (state_ff == LOGI) ##1 (state_ff == LOGA && ramWr_ff.we);
  endsequence

  dbca_zero_a: assert property (!statusWord[1]) // R16
    else $error("bus control acceptance bit set");
  ignore_quiet_a: assert property ( // R14
    msgStart && state_ff == IDLE && ignoreCmd |=>
    !respValid_ff && $stable(meFlag_ff))
    else $error("ignored command changed status");
  illegal_me_a: assert property ( // R13
    msgStart && state_ff == IDLE && !ignoreCmd && msgEvt.illegal &&
    !msgEvt.broadcast |=>
    meFlag_ff && respKind_ff == rt_circ_pkg::RESP_STATUS)
    else $error("illegal command reply wrong");
  bus_wide_marker_nosend_a: assert property ( // R10
    msgStart && state_ff == IDLE && noXmit && !msgEvt.modeCmd |=>
    respKind_ff == rt_circ_pkg::RESP_NONE)
    else $error("broadcast transmit answered");
  // The tag write still shows in the first idle cycle; look one later.
  bad_hold_a: assert property ( // R21
    state_ff == TTAG && !goodMsg |=> state_ff == IDLE ##1 !ramWr_ff.we)
    else $error("pointer written after bad message");
  full_reload_a: assert property ( // R4
    state_ff == DMIBA && fullCount |->
    ##1 ramWr_ff.data == (evt_ff.mibaPtr & ~lowMask))
    else $error("info pointer not reloaded");
  info_first_a: assert property ( // R2
    state_ff == INFO |=> ramWr_ff.addr == evt_ff.mibaPtr
    ##1 ramWr_ff.addr == evt_ff.mibaPtr + 16'h0001)
    else $error("info and tag order wrong");
  log_irq_a: assert property ( // R20
    logWrites |=> ##1 pend_ff[1] && msgIntLine_ff)
    else $error("log not followed by interrupt");
  bdone_gate_a: assert property ( // R5
    $rose(pend_ff[0]) |-> $past(ier_ff[0]) && evt_ff.ctrl[2])
    else $error("block done without enables");
  ahb_wait_a: assert property (ahbTake && hreadyout_ff |=>
    !hreadyout_ff ##1 hreadyout_ff)
    else $error("bus wait state wrong");

endmodule

// ### dv/bc_engine_model.sv
`timescale 1ns/1ps
// Stand-in for the decoder side: command strobe, word strobes, end of message.
module bc_engine_model (
  // Clock.
  input wire logic ref_clk,
  // Message strobes toward the block.
  output logic msgStart,
  output rt_circ_pkg::msg_evt_t msgEvt,
  output logic rxValid,
  output logic [15:0] rxWord,
  output logic txReq,
  output logic msgEnd,
  output logic msgError,
  output logic gapError
);
  // Everything idles low so nothing is taken during reset.
  initial begin
    msgStart = 1'b0;
    msgEvt = '0;
    rxValid = 1'b0;
    rxWord = 16'h0000;
    txReq = 1'b0;
    msgEnd = 1'b0;
    msgError = 1'b0;
    gapError = 1'b0;
  end

  // One whole message; a mode command gets no word strobes and no end pulse.
  task automatic send(input rt_circ_pkg::msg_evt_t e, input logic err,
                      input logic gap, input logic [15:0] base);
    int n;
    n = e.modeCmd ? 0 : int'(e.wordCount);
    msgEvt <= e;
    msgStart <= 1'b1;
    @(posedge ref_clk);
    msgStart <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxValid <= !e.txNotRx;
      txReq <= e.txNotRx;
      rxWord <= base + 16'(i);
      @(posedge ref_clk);
      rxValid <= 1'b0;
      txReq <= 1'b0;
      // A released word line shows the inverse, never a stale copy.
      rxWord <= ~(base + 16'(i));
      @(posedge ref_clk);
    end
    msgEnd <= !e.modeCmd;
    msgError <= err;
    gapError <= gap;
    @(posedge ref_clk);
    msgEnd <= 1'b0;
    // The block needs at least four idle cycles before the next command.
    repeat (11) @(posedge ref_clk);
  endtask
endmodule

// ### dv/tb_rt_circular_buffer_and_mode_cmd.sv
`timescale 1ns/1ps
module tb_rt_circular_buffer_and_mode_cmd;
  // Clock, reset and AHB master side.
  logic refClk = 1'b0;
  logic resetN = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp;
  // Message path and block outputs.
  logic msgStart, rxValid, txReq, msgEnd, msgError, gapError;
  logic respValid, fetchValid, msgIntLine;
  logic [15:0] rxWord, statusWord, fetchAddr;
  rt_circ_pkg::msg_evt_t msgEvt;
  rt_circ_pkg::resp_t respKind, lastKind;
  rt_circ_pkg::ram_wr_t ramWr;
  // Bookkeeping: counts, captured writes and fetches, expectations.
  int errors = 0;
  int nTests = 0;
  int nResp = 0;
  int wqAtIrq = 0;
  logic lastLine = 1'b0;
  logic [31:0] wq[$], eq[$];
  logic [15:0] fq[$], efq[$];
  localparam logic [7:0] OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                                      8'h14, 8'h20};

  always #50 refClk = ~refClk;

  rt_circular_buffer_and_mode_cmd uut (.ref_clk(refClk), .reset_n(resetN),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .msgStart(msgStart),
    .msgEvt(msgEvt), .rxValid(rxValid), .rxWord(rxWord), .txReq(txReq),
    .msgEnd(msgEnd), .msgError(msgError), .gapError(gapError),
    .respValid(respValid), .respKind(respKind), .statusWord(statusWord),
    .ramWr(ramWr), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .msgIntLine(msgIntLine));

  bc_engine_model pm (.ref_clk(refClk), .msgStart(msgStart),
    .msgEvt(msgEvt), .rxValid(rxValid), .rxWord(rxWord), .txReq(txReq),
    .msgEnd(msgEnd), .msgError(msgError), .gapError(gapError));

  // Monitor: records RAM writes, fetches, replies and when the line rises.
  always @(posedge refClk) begin
    // The line is looked at before this edge's write is counted.
    if (msgIntLine === 1'b1 && !lastLine) wqAtIrq = wq.size();
    lastLine = msgIntLine;
    if (ramWr.we === 1'b1) wq.push_back({ramWr.addr, ramWr.data});
    if (fetchValid === 1'b1) fq.push_back(fetchAddr);
    if (respValid === 1'b1) begin
      nResp++;
      lastKind = respKind;
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits for hready high; a stuck slave ends the run instead of hanging.
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge refClk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (k >= 40) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // One single AHB-Lite transfer; entered just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  function automatic logic undef(input logic tr, input logic [4:0] c);
    return tr ? (c == 5'h11 || c == 5'h14 || c == 5'h15)
              : (c <= 5'h10 || c == 5'h12 || c == 5'h13);
  endfunction

  // One subaddress message with every RAM write and fetch predicted.
  task automatic sub_msg(input rt_circ_pkg::msg_evt_t e, input logic err,
                         input logic gap, input logic bwm, output logic full);
    logic [15:0] base, mask, info;
    logic good;
    base = 16'($urandom);
    mask = (16'h0001 << e.ctrl[7:4]) - 16'h0001;
    full = ((e.mibaPtr + 16'h0001) & mask) == mask;
    good = !err && !e.busy && !e.illegal && !(e.txNotRx && e.broadcast);
    info = {err, e.busy, bwm ? e.broadcast : gap, e.illegal, e.txNotRx,
            e.code, 1'b0, e.wordCount};
    wq.delete();
    fq.delete();
    eq.delete();
    efq.delete();
    for (int i = 0; i < int'(e.wordCount); i++) begin
      if (!e.txNotRx) eq.push_back({e.currPtr + 16'(i), base + 16'(i)});
      else if (!e.broadcast) efq.push_back(e.currPtr + 16'(i));
    end
    eq.push_back({e.mibaPtr, info});
    eq.push_back({e.mibaPtr + 16'h0001, e.timeTag});
    if (good) begin
      eq.push_back({e.descAddr + 16'h0002,
                    full ? e.startPtr : e.currPtr + 16'(e.wordCount)});
      eq.push_back({e.descAddr + 16'h0003,
                    full ? e.mibaPtr & ~mask : e.mibaPtr + 16'h0002});
    end
    lastKind = rt_circ_pkg::RESP_NONE;
    pm.send(e, err, gap, base);
    chk("write count", 32'(wq.size()), 32'(eq.size()));
    foreach (eq[i]) chk("ram write", wq[i], eq[i]);
    chk("fetch count", 32'(fq.size()), 32'(efq.size()));
    foreach (efq[i]) chk("fetch", 32'(fq[i]), 32'(efq[i]));
    if (e.broadcast && e.txNotRx)
      chk("no reply", 32'(lastKind), 32'(rt_circ_pkg::RESP_NONE));
    full = full && good;
  endtask

  // Main sequence.
  initial begin
    rt_circ_pkg::msg_evt_t e;
    logic full, hit;
    logic [15:0] ca, msg_info_pointer;
    int n0, j;
    void'($urandom(32'hb2b4c640));
    repeat (6) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    // Every register starts at zero; a read-only or unmapped place stays so.
    foreach (OFFS[i]) rchk("reset value", OFFS[i], 32'h0);
    ahb(1'b1, 8'h20, 32'hffffffff);
    ahb(1'b1, rt_circ_pkg::STAT_OFS, 32'hffffffff);
    rchk("unmapped", 8'h20, 32'h0);
    rchk("status ro", rt_circ_pkg::STAT_OFS, 32'h0);
    // Four blocks: marker and interrupt enable in every mix; size code 3 with the enable, else 2; control enable off in the last.
    for (int b = 0; b < 4; b++) begin
      ahb(1'b1, rt_circ_pkg::CFG1_OFS, 32'h2);
      ahb(1'b1, rt_circ_pkg::CFG2_OFS, {28'h0, b[1], 3'h0});
      ahb(1'b1, rt_circ_pkg::IER_OFS, {31'h0, b[0]});
      ca = 16'h0400;
      msg_info_pointer = 16'h0800;
      e = '0;
      e.ctrl = {8'h00, 4'(b % 2 + 2), 1'b0, b != 3, 2'h0};
      e.descAddr = 16'h0040;
      e.startPtr = 16'h0400;
      j = 0;
      do begin
        e.txNotRx = 1'($urandom);
        e.broadcast = ($urandom % 4) == 0;
        e.rt31 = e.broadcast;
        e.code = 5'($urandom);
        e.wordCount = 5'($urandom % 4 + 1);
        e.timeTag = 16'($urandom);
        e.currPtr = ca;
        e.mibaPtr = msg_info_pointer;
        e.busy = j == 3;
        sub_msg(e, j == 1, 1'($urandom), b[1], full);
        if (j != 1 && j != 3 && !(e.txNotRx && e.broadcast)) begin
          ca = full ? 16'h0400 : ca + 16'(e.wordCount);
          msg_info_pointer = full ? 16'h0800 : msg_info_pointer + 16'h0002;
        end
        chk("block irq", 32'(msgIntLine), 32'(full && b == 1));
        j++;
      end while (!full && j < 20);
      chk("block end", 32'(full), 32'h1);
      rchk("pending", rt_circ_pkg::PEND_OFS, {31'h0, b == 1});
      ahb(1'b1, rt_circ_pkg::PEND_OFS, 32'h1);
      chk("line cleared", 32'(msgIntLine), 32'h0);
    end
    // All 64 mode commands, odd codes illegal; undefined ones ignored first.
    for (int u = 1; u >= 0; u--) begin
      ahb(1'b1, rt_circ_pkg::CFG1_OFS, 32'(u));
      for (int m = 0; m < 64; m++) begin
        e = '0;
        e.modeCmd = 1'b1;
        e.txNotRx = m[5];
        e.code = m[4:0];
        e.illegal = m[0];
        n0 = nResp;
        j = int'(statusWord);
        pm.send(e, 1'b0, 1'b0, 16'h0);
        chk("replies", 32'(nResp - n0),
            32'(!(u == 1 && undef(m[5], m[4:0]))));
        if (nResp == n0) chk("status kept", 32'(statusWord), 32'(j));
        else begin
          chk("reply kind", 32'(lastKind), 32'(m[5] && m[4] && !m[0] ?
            rt_circ_pkg::RESP_STATUS_DATA : rt_circ_pkg::RESP_STATUS));
          chk("mode error", 32'(statusWord[10]), 32'(m[0]));
        end
        chk("dbca bit", 32'(statusWord[1]), 32'h0);
      end
    end
    // Illegal mode commands: status only, with the error bit set.
    repeat (4) begin
      e.illegal = 1'b1;
      e.txNotRx = 1'b1;
      e.code = 5'($urandom % 16 + 16);
      pm.send(e, 1'b0, 1'b0, 16'h0);
      chk("illegal kind", 32'(lastKind), 32'(rt_circ_pkg::RESP_STATUS));
      chk("error bit", 32'(statusWord[10]), 32'h1);
    end
    // A reset in mid-run clears the invalid option again.
    ahb(1'b1, rt_circ_pkg::CFG1_OFS, 32'h1);
    resetN <= 1'b0;
    repeat (2) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    rchk("cfg after reset", rt_circ_pkg::CFG1_OFS, 32'h0);
    // Interrupt when accessed: log first, then pending and the line.
    // Broadcast uses its own control bit and codes 0-15 only.
    for (int k = 0; k < 4; k++) begin
      hit = k % 2 == 0;
      ahb(1'b1, rt_circ_pkg::IER_OFS, k == 1 ? 32'h0 : 32'h2);
      e = '0;
      e.modeCmd = 1'b1;
      e.txNotRx = 1'b1;
      e.broadcast = k >= 2;
      e.code = 5'($urandom);
      if (k >= 2) e.code[4] = k == 3;
      e.ctrl = k >= 2 ? 16'h4000 : 16'h8000;
      wq.delete();
      pm.send(e, 1'b0, 1'b0, 16'h0);
      chk("iwa line", 32'(msgIntLine), 32'(hit));
      rchk("iwa pending", rt_circ_pkg::PEND_OFS, {30'h0, hit, 1'b0});
      if (k == 0) begin
        chk("log info", wq[0], {rt_circ_pkg::LOG_BASE,
                                rt_circ_pkg::IIW_IWA});
        chk("log addr", wq[1], {rt_circ_pkg::LOG_BASE + 16'h0001,
          rt_circ_pkg::MODE_DESC_BASE + 16'({1'b1, e.code, 2'b00})});
        chk("log first", 32'(wqAtIrq), 32'h2);
      end
      if (hit) begin
        ahb(1'b1, rt_circ_pkg::PEND_OFS, 32'h2);
        chk("iwa cleared", 32'(msgIntLine), 32'h0);
      end
    end
    tally_and_finish();
  end
endmodule
